/* sim/hpsc_ctrl_bench.sv */
`default_nettype none
module hpsc_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] ofs = hpsc_pkg::STAGE_CTRL_OFS;
   logic CLK = 1'h0, NRST = 1'h0, WR = 1'h0, RD = 1'h0;
   logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA;
   wire logic [7:0] o;
   int n_fail = 0, compares = 0;
   hpsc_ctrl uut (.CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .LEFT_HP_SHORT_RELEASE(o[7]), .LEFT_HP_OUTPUT_STAGE_ON(o[6]),
      .LEFT_HP_MIDDLE_STAGE_ON(o[5]), .LEFT_HP_INPUT_STAGE_ON(o[4]),
      .RIGHT_HP_SHORT_RELEASE(o[3]), .RIGHT_HP_OUTPUT_STAGE_ON(o[2]),
      .RIGHT_HP_MIDDLE_STAGE_ON(o[1]), .RIGHT_HP_INPUT_STAGE_ON(o[0]));
   initial begin
      forever #5 CLK = ~CLK;
   end
   task automatic chk_pins(input logic [7:0] exp);
      compares++;
      if (o !== exp) begin
         n_fail++;
         $display("CHECK FAILED %0t pins %h exp %h", $time, o, exp);
      end
   endtask
   task automatic chk_rdata(input logic [7:0] exp);
      compares++;
      if (RDATA !== exp) begin
         n_fail++;
         $display("CHECK FAILED %0t rdata %h exp %h", $time, RDATA, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'h1;
      @(posedge CLK);
      WR <= 1'h0;
      #1 chk_pins(exp);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'h1;
      @(posedge CLK);
      RD <= 1'h0;
      #1 chk_rdata(exp);
      @(posedge CLK);
      #1 chk_rdata(hpsc_pkg::RDATA_IDLE);
   endtask
   task automatic reset_seq;
      @(posedge CLK);
      NRST <= 1'h0;
      #1 chk_pins(hpsc_pkg::STAGE_CTRL_RST);
      chk_rdata(hpsc_pkg::RDATA_IDLE);
      repeat (hpsc_pkg::RST_HOLD_CYC) @(posedge CLK);
      NRST <= 1'h1;
      repeat (hpsc_pkg::RST_SYNC_CYC + 1) @(posedge CLK);
      #1 chk_pins(hpsc_pkg::STAGE_CTRL_RST);
      rd(ofs, hpsc_pkg::STAGE_CTRL_RST);
   endtask
   task automatic t_bits;
      for (int i = 0; i < 8; i++) begin
         wr(ofs, 8'h01 << i, 8'h01 << i);
         rd(ofs, 8'h01 << i);
      end
      wr(ofs, 8'h00, 8'h00);
   endtask
   task automatic t_seq;
      wr(ofs, 8'h11, 8'h11);
      repeat (hpsc_pkg::STAGE_GAP_CYC) @(posedge CLK);
      wr(ofs, 8'h33, 8'h33);
      wr(ofs, 8'h77, 8'h77);
      wr(ofs, 8'hff, 8'hff);
      wr(ofs + 8'h01, 8'h00, 8'hff);
      rd(ofs + 8'h01, hpsc_pkg::RDATA_IDLE);
      rd(ofs - 8'h01, hpsc_pkg::RDATA_IDLE);
      rd(ofs, 8'hff);
      wr(ofs, 8'h77, 8'h77);
      wr(ofs, 8'h00, 8'h00);
      wr(ofs, 8'hff, 8'hff);
   endtask
   task automatic close_out;
      $display("fails %0d compares %0d", n_fail, compares);
      if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #100us;
      n_fail++;
      close_out();
   end
   initial begin
      reset_seq();
      t_bits();
      t_seq();
      reset_seq();
      close_out();
   end
endmodule
`default_nettype wire

/* src/hpsc_ctrl.sv */
// Operation
// - Bit 7 releases left output short
// - Bit 6 enables left output stage
// - Bit 5 enables left intermediate stage
// - Bit 4 enables left input stage
// - Bit 3 releases right output short
// - Bit 2 enables right output stage
// - Bit 1 enables right intermediate stage
// - Bit 0 enables right input stage
// - Both outputs shorted out of reset
`default_nettype none
module hpsc_ctrl (
   // Clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // Register port
   input wire logic [hpsc_pkg::ADDR_W-1:0] ADDR,
   input wire logic [hpsc_pkg::DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [hpsc_pkg::DATA_W-1:0] RDATA,
   // Left headphone driver controls
   output logic LEFT_HP_SHORT_RELEASE,
   output logic LEFT_HP_OUTPUT_STAGE_ON,
   output logic LEFT_HP_MIDDLE_STAGE_ON,
   output logic LEFT_HP_INPUT_STAGE_ON,
   // Right headphone driver controls
   output logic RIGHT_HP_SHORT_RELEASE,
   output logic RIGHT_HP_OUTPUT_STAGE_ON,
   output logic RIGHT_HP_MIDDLE_STAGE_ON,
   output logic RIGHT_HP_INPUT_STAGE_ON
);
   logic rst_meta_r;
   logic rst_sync_r;
   logic [7:0] ctrl_r;
   logic [7:0] rdata_r;
   logic wr_hit;
   logic rd_hit;

   // Register select; shared by write, read and the checks
   function automatic logic reg_hit(input logic [hpsc_pkg::ADDR_W-1:0] addr);
      return addr == hpsc_pkg::STAGE_CTRL_OFS;
   endfunction

   assign wr_hit = WR && reg_hit(ADDR);
   assign rd_hit = RD && reg_hit(ADDR);

   // Reset release synchroniser
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rst_meta_r <= 1'h0;
         rst_sync_r <= 1'h0;
      end else begin
         rst_meta_r <= 1'h1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // Stage control register; shorts held after reset
   always_ff @(posedge CLK or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         ctrl_r <= hpsc_pkg::STAGE_CTRL_RST;
      end else if (wr_hit) begin
         ctrl_r <= WDATA;
      end
   end

   // Read data, zero for unmapped addresses
   always_ff @(posedge CLK or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         rdata_r <= hpsc_pkg::RDATA_IDLE;
      end else if (rd_hit) begin
         rdata_r <= ctrl_r;
      end else begin
         rdata_r <= hpsc_pkg::RDATA_IDLE;
      end
   end

   assign RDATA = rdata_r;
   assign LEFT_HP_SHORT_RELEASE = ctrl_r[hpsc_pkg::BIT_L_SHORT];
   assign LEFT_HP_OUTPUT_STAGE_ON = ctrl_r[hpsc_pkg::BIT_L_OUTP];
   assign LEFT_HP_MIDDLE_STAGE_ON = ctrl_r[hpsc_pkg::BIT_L_MID];
   assign LEFT_HP_INPUT_STAGE_ON = ctrl_r[hpsc_pkg::BIT_L_IN];
   assign RIGHT_HP_SHORT_RELEASE = ctrl_r[hpsc_pkg::BIT_R_SHORT];
   assign RIGHT_HP_OUTPUT_STAGE_ON = ctrl_r[hpsc_pkg::BIT_R_OUTP];
   assign RIGHT_HP_MIDDLE_STAGE_ON = ctrl_r[hpsc_pkg::BIT_R_MID];
   assign RIGHT_HP_INPUT_STAGE_ON = ctrl_r[hpsc_pkg::BIT_R_IN];

   // Each output follows the bit written one cycle earlier
   a_left_short: assert property (
      @(posedge CLK) disable iff (!rst_sync_r)
      wr_hit
      |=> LEFT_HP_SHORT_RELEASE == $past(WDATA[hpsc_pkg::BIT_L_SHORT]))
      else $error("left short release does not follow write");

   a_left_outp: assert property (
      @(posedge CLK) disable iff (!rst_sync_r)
      wr_hit
      |=> LEFT_HP_OUTPUT_STAGE_ON == $past(WDATA[hpsc_pkg::BIT_L_OUTP]))
      else $error("left output stage does not follow write");

   a_left_mid: assert property (
      @(posedge CLK) disable iff (!rst_sync_r)
      wr_hit
      |=> LEFT_HP_MIDDLE_STAGE_ON == $past(WDATA[hpsc_pkg::BIT_L_MID]))
      else $error("left middle stage does not follow write");

   a_left_in: assert property (
      @(posedge CLK) disable iff (!rst_sync_r)
      wr_hit
      |=> LEFT_HP_INPUT_STAGE_ON == $past(WDATA[hpsc_pkg::BIT_L_IN]))
      else $error("left input stage does not follow write");

   a_right_short: assert property (
      @(posedge CLK) disable iff (!rst_sync_r)
      wr_hit
      |=> RIGHT_HP_SHORT_RELEASE == $past(WDATA[hpsc_pkg::BIT_R_SHORT]))
      else $error("right short release does not follow write");

   a_right_outp: assert property (
      @(posedge CLK) disable iff (!rst_sync_r)
      wr_hit
      |=> RIGHT_HP_OUTPUT_STAGE_ON == $past(WDATA[hpsc_pkg::BIT_R_OUTP]))
      else $error("right output stage does not follow write");

   a_right_mid: assert property (
      @(posedge CLK) disable iff (!rst_sync_r)
      wr_hit
      |=> RIGHT_HP_MIDDLE_STAGE_ON == $past(WDATA[hpsc_pkg::BIT_R_MID]))
      else $error("right middle stage does not follow write");

   a_right_in: assert property (
      @(posedge CLK) disable iff (!rst_sync_r)
      wr_hit
      |=> RIGHT_HP_INPUT_STAGE_ON == $past(WDATA[hpsc_pkg::BIT_R_IN]))
      else $error("right input stage does not follow write");

   // Register holds without a write; other addresses leave it alone
   a_short_held: assert property (
      @(posedge CLK) disable iff (!rst_sync_r)
      !wr_hit
      |=> $stable(ctrl_r))
      else $error("control changed without a write");

   a_refused_write: assert property (
      @(posedge CLK) disable iff (!rst_sync_r)
      WR && !reg_hit(ADDR)
      |=> $stable(ctrl_r))
      else $error("write to another address changed control");

   // Shorts applied in reset and kept until software releases them
   a_reset_shorts: assert property (
      @(posedge CLK)
      !rst_sync_r
      |-> !LEFT_HP_SHORT_RELEASE && !RIGHT_HP_SHORT_RELEASE)
      else $error("output short released during reset");

   a_release_quiet: assert property (
      @(posedge CLK)
      $rose(rst_sync_r)
      |-> ctrl_r == hpsc_pkg::STAGE_CTRL_RST)
      else $error("control not at reset value after release");

   a_left_release: assert property (
      @(posedge CLK) disable iff (!rst_sync_r)
      $rose(LEFT_HP_SHORT_RELEASE)
      |-> $past(wr_hit) && $past(WDATA[hpsc_pkg::BIT_L_SHORT]))
      else $error("left short released without a write of one");

   a_right_release: assert property (
      @(posedge CLK) disable iff (!rst_sync_r)
      $rose(RIGHT_HP_SHORT_RELEASE)
      |-> $past(wr_hit) && $past(WDATA[hpsc_pkg::BIT_R_SHORT]))
      else $error("right short released without a write of one");

   // Read data one cycle after the strobe, idle otherwise
   a_read_back: assert property (
      @(posedge CLK) disable iff (!rst_sync_r)
      rd_hit && !WR
      |=> RDATA == $past(ctrl_r))
      else $error("read data wrong");

   a_read_idle: assert property (
      @(posedge CLK) disable iff (!rst_sync_r)
      !rd_hit
      |=> RDATA == hpsc_pkg::RDATA_IDLE)
      else $error("read data not idle without a read");

   a_reset_rdata: assert property (
      @(posedge CLK)
      !rst_sync_r
      |-> RDATA == hpsc_pkg::RDATA_IDLE)
      else $error("read data not idle during reset");

   // Main scenarios
   c_left_up: cover property (
      @(posedge CLK) disable iff (!rst_sync_r)
      LEFT_HP_INPUT_STAGE_ON ##[1:1000] LEFT_HP_SHORT_RELEASE);

   c_right_up: cover property (
      @(posedge CLK) disable iff (!rst_sync_r)
      RIGHT_HP_INPUT_STAGE_ON ##[1:1000] RIGHT_HP_SHORT_RELEASE);

   c_read: cover property (
      @(posedge CLK) disable iff (!rst_sync_r)
      rd_hit);

   c_refused_write: cover property (
      @(posedge CLK) disable iff (!rst_sync_r)
      WR && !reg_hit(ADDR));

   c_shutdown: cover property (
      @(posedge CLK) disable iff (!rst_sync_r)
      LEFT_HP_SHORT_RELEASE ##1 !LEFT_HP_SHORT_RELEASE && LEFT_HP_INPUT_STAGE_ON);
endmodule
`default_nettype wire

/* src/hpsc_pkg.sv */
`default_nettype none
package hpsc_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] STAGE_CTRL_OFS = 8'h5a;
   localparam logic [7:0] STAGE_CTRL_RST = 8'h00;
   localparam logic [7:0] RDATA_IDLE = 8'h00;
   localparam int RST_HOLD_CYC = 16;
   localparam int RST_SYNC_CYC = 2;
   // Input stage to middle stage gap, 20 us at 100 MHz
   localparam int STAGE_GAP_CYC = 2000;
   localparam int BIT_L_SHORT = 7;
   localparam int BIT_L_OUTP = 6;
   localparam int BIT_L_MID = 5;
   localparam int BIT_L_IN = 4;
   localparam int BIT_R_SHORT = 3;
   localparam int BIT_R_OUTP = 2;
   localparam int BIT_R_MID = 1;
   localparam int BIT_R_IN = 0;
endpackage
`default_nettype wire
